/* cmpgen_deadband.v */
`timescale 1ns/1ps
module cmpgen_deadband
(
	input wire clk_sys_i,
	input wire reset_n_i,
	input wire tick_i,
	input wire clear_i,
	input wire edge_i,
	input wire [5:0] count_i,
	output wire done_o
);
	// one per edge direction so both delays are programmed apart
	reg [5:0] remain;
	reg busy;
	assign done_o = !busy && !edge_i;
	always @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			remain <= 6'h00;
			busy <= 1'b0;
		end
		else if (clear_i)
		begin
			remain <= 6'h00;
			busy <= 1'b0;
		end
		else if (edge_i)
		begin
			remain <= count_i;
			busy <= (count_i != 6'h00);
		end
		else if (busy && tick_i)
		begin
			remain <= remain - 6'h01;
			busy <= (remain != 6'h01);
		end
	end
endmodule

/* cmpgen_defines.vh */
`ifndef CMPGEN_DEFINES_VH
`define CMPGEN_DEFINES_VH
`define CMPGEN_ADDR_OUTCTL 12'h000
`define CMPGEN_ADDR_INSEL 12'h004
`define CMPGEN_ADDR_SHDCTL 12'h008
`define CMPGEN_ADDR_DBR 12'h00c
`define CMPGEN_ADDR_DBF 12'h010
`define CMPGEN_ADDR_STATUS 12'h014
`define CMPGEN_OC_EN 7
`define CMPGEN_OC_OEB 6
`define CMPGEN_OC_OEA 5
`define CMPGEN_OC_POLB 4
`define CMPGEN_OC_POLA 3
`define CMPGEN_OC_CS 0
`define CMPGEN_SD_ASE 7
`define CMPGEN_SD_ARSEN 6
`define CMPGEN_SD_LVLB 5
`define CMPGEN_SD_LVLA 4
`define CMPGEN_SD_SRC_HI 3
`define CMPGEN_SD_SRC_LO 0
`define CMPGEN_IS_HI 2
`define CMPGEN_IS_LO 0
`define CMPGEN_RST_OUTCTL 8'h00
`define CMPGEN_RST_INSEL 8'h00
`define CMPGEN_RST_SHDCTL 8'h00
`define CMPGEN_RST_DB 6'h00
`define CMPGEN_SYS_CLK_KHZ 200000
`define CMPGEN_FAST_OSC_KHZ 16000
`define CMPGEN_ACT_WINDOW 8'hff
`endif

/* cmpgen_power_stage.sv */
`timescale 1ns/1ps
// gate drivers with pull-downs: a released input reads low
module cmpgen_power_stage
(
	input wire drive_a_i,
	input wire drive_a_oe_n_i,
	input wire drive_b_i,
	input wire drive_b_oe_n_i,
	output wire pin_a_o,
	output wire pin_b_o
);
	assign pin_a_o = drive_a_oe_n_i ? 1'b0 : drive_a_i;
	assign pin_b_o = drive_b_oe_n_i ? 1'b0 : drive_b_i;
endmodule

/* cmpgen_properties.sv */
`timescale 1ns/1ps
module cmpgen_properties
(
	input wire clk_sys_i,
	input wire reset_n_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	input wire pready_o,
	input wire pslverr_o,
	input wire [3:0] shutdown_src_i,
	input wire drive_output_a_o,
	input wire drive_output_a_oe_n_o,
	input wire drive_output_b_o,
	input wire drive_output_b_oe_n_o,
	input wire fast_osc_request_o
);
	reg [7:0] oc;
	reg [7:0] sc;
	wire wr = psel_i & penable_i & pready_o & pwrite_i;
	wire hit = |(shutdown_src_i & sc[3:0]) & oc[7] & oc[5];
	// override a low keeps shutdown from looking like overlap
	wire pol_hi = oc[7] & oc[4] & oc[3] & !sc[4];
	wire overlap = drive_output_a_o & drive_output_b_o;
	wire oe_off = drive_output_a_oe_n_o & drive_output_b_oe_n_o;
	always @(posedge clk_sys_i or negedge reset_n_i)
		if (!reset_n_i)
		begin
			oc <= 8'h00;
			sc <= 8'h00;
		end
		else if (wr && paddr_i == 12'h000)
			oc <= pwdata_i[7:0];
		else if (wr && paddr_i == 12'h008)
			sc <= pwdata_i[7:0];
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (!reset_n_i);
	ready_setup_a: assert property (psel_i & !penable_i |=> pready_o)
		else $error("ready late");
	ready_pulse_a: assert property (pready_o |=> !pready_o)
		else $error("ready held");
	unmapped_err_a: assert property (pready_o & paddr_i > 12'h014 |-> pslverr_o)
		else $error("no slave error");
	pin_release_a: assert property (!oc[5] [*4] |-> drive_output_a_oe_n_o)
		else $error("pin a still driven");
	enable_gate_a: assert property (!oc[7] [*4] |-> oe_off)
		else $error("pins driven while off");
	override_pin_a: assert property (hit [*6] |-> drive_output_a_o == sc[4])
		else $error("override level missing");
	no_overlap_a: assert property (pol_hi [*4] |-> !overlap)
		else $error("both drives active");
	osc_drop_a: assert property (!oc[7] [*3] |-> !fast_osc_request_o)
		else $error("oscillator kept while off");
	cover property (hit);
	cover property (pready_o & pslverr_o);
	cover property (pol_hi & drive_output_a_o);
endmodule

bind cmpgen_top cmpgen_properties chk_u (.*);

/* cmpgen_sync.v */
`timescale 1ns/1ps
module cmpgen_sync
#(
	parameter WIDTH = 1
)
(
	input wire clk_sys_i,
	input wire reset_n_i,
	input wire [WIDTH-1:0] async_i,
	output reg [WIDTH-1:0] sync_o
);
	reg [WIDTH-1:0] stage1;
	always @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			stage1 <= {WIDTH{1'b0}};
			sync_o <= {WIDTH{1'b0}};
		end
		else
		begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end
endmodule

/* cmpgen_top.v */
`timescale 1ns/1ps
`include "cmpgen_defines.vh"
module cmpgen_top
(
	input wire clk_sys_i,
	input wire reset_n_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	output reg [31:0] prdata_o,
	output reg pready_o,
	output reg pslverr_o,
	input wire [3:0] pwm_out_i,
	input wire oscillator_output_i,
	input wire logic_cell_output_i,
	input wire [3:0] shutdown_src_i,
	input wire sleep_i,
	output reg drive_output_a_o,
	output reg drive_output_a_oe_n_o,
	output reg drive_output_b_o,
	output reg drive_output_b_oe_n_o,
	output reg fast_osc_request_o
);
	localparam [1:0] ST_SHUT = 2'b01;
	localparam [1:0] ST_RUN = 2'b10;
	// divider ratio for the fast-oscillator tick, derived from the rates
	localparam integer FAST_DIV =
		`CMPGEN_SYS_CLK_KHZ / `CMPGEN_FAST_OSC_KHZ;
	localparam [3:0] FAST_DIV_M1 = FAST_DIV[3:0] - 4'h1;

	reg [7:0] output_control_reg;
	reg [7:0] input_select_reg;
	reg [7:0] shutdown_control_reg;
	reg [5:0] rising_deadband_count;
	reg [5:0] falling_deadband_count;
	reg [1:0] state;
	reg [3:0] div_cnt;
	reg fast_tick;
	reg src_d;
	reg a_on;
	reg b_on;
	reg [31:0] next_prdata;
	reg next_slverr;
	reg src_sel;
	reg [7:0] act_cnt;

	wire [3:0] pwm_s;
	wire osc_s;
	wire lc_s;
	wire [3:0] sd_s;
	wire module_enable = output_control_reg[`CMPGEN_OC_EN];
	wire output_a_enable = output_control_reg[`CMPGEN_OC_OEA];
	wire output_b_enable = output_control_reg[`CMPGEN_OC_OEB];
	wire output_a_polarity = output_control_reg[`CMPGEN_OC_POLA];
	wire output_b_polarity = output_control_reg[`CMPGEN_OC_POLB];
	wire module_clock_select = output_control_reg[`CMPGEN_OC_CS];
	wire [2:0] input_source_select =
		input_select_reg[`CMPGEN_IS_HI:`CMPGEN_IS_LO];
	wire shutdown_event = shutdown_control_reg[`CMPGEN_SD_ASE];
	wire auto_restart_enable = shutdown_control_reg[`CMPGEN_SD_ARSEN];
	wire override_level_a = shutdown_control_reg[`CMPGEN_SD_LVLA];
	wire override_level_b = shutdown_control_reg[`CMPGEN_SD_LVLB];
	wire [3:0] sd_select =
		shutdown_control_reg[`CMPGEN_SD_SRC_HI:`CMPGEN_SD_SRC_LO];
	wire sd_active = |(sd_s & sd_select);
	wire wr = psel_i && penable_i && pwrite_i && pready_o;
	wire tick = module_clock_select ? fast_tick : 1'b1;
	wire rise = src_sel && !src_d;
	wire fall = !src_sel && src_d;
	wire rise_done;
	wire fall_done;

	cmpgen_sync #(.WIDTH(4)) u_sync_pwm
	(
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.async_i(pwm_out_i),
		.sync_o(pwm_s)
	);
	cmpgen_sync #(.WIDTH(1)) u_sync_osc
	(
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.async_i(oscillator_output_i),
		.sync_o(osc_s)
	);
	cmpgen_sync #(.WIDTH(1)) u_sync_lc
	(
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.async_i(logic_cell_output_i),
		.sync_o(lc_s)
	);
	cmpgen_sync #(.WIDTH(4)) u_sync_sd
	(
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.async_i(shutdown_src_i),
		.sync_o(sd_s)
	);

	// codes 6 and 7 have no source and read as low
	always @*
	begin
		case (input_source_select)
			3'd0: src_sel = pwm_s[0];
			3'd1: src_sel = pwm_s[1];
			3'd2: src_sel = pwm_s[2];
			3'd3: src_sel = pwm_s[3];
			3'd4: src_sel = osc_s;
			3'd5: src_sel = lc_s;
			default: src_sel = 1'b0;
		endcase
	end

	always @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			div_cnt <= 4'h0;
			fast_tick <= 1'b0;
		end
		else if (div_cnt == FAST_DIV_M1)
		begin
			div_cnt <= 4'h0;
			fast_tick <= 1'b1;
		end
		else
		begin
			div_cnt <= div_cnt + 4'h1;
			fast_tick <= 1'b0;
		end
	end

	cmpgen_deadband u_db_rise
	(
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.tick_i(tick),
		.clear_i(!module_enable),
		.edge_i(rise),
		.count_i(rising_deadband_count),
		.done_o(rise_done)
	);
	cmpgen_deadband u_db_fall
	(
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.tick_i(tick),
		.clear_i(!module_enable),
		.edge_i(fall),
		.count_i(falling_deadband_count),
		.done_o(fall_done)
	);

	// apb: zero wait states, unmapped addresses answer with pslverr
	always @*
	begin
		next_prdata = 32'h0000_0000;
		next_slverr = 1'b0;
		if (paddr_i == `CMPGEN_ADDR_OUTCTL)
			next_prdata = {24'h000000, output_control_reg};
		else if (paddr_i == `CMPGEN_ADDR_INSEL)
			next_prdata = {24'h000000, input_select_reg};
		else if (paddr_i == `CMPGEN_ADDR_SHDCTL)
			next_prdata = {24'h000000, shutdown_control_reg};
		else if (paddr_i == `CMPGEN_ADDR_DBR)
			next_prdata = {26'h0, rising_deadband_count};
		else if (paddr_i == `CMPGEN_ADDR_DBF)
			next_prdata = {26'h0, falling_deadband_count};
		else if (paddr_i == `CMPGEN_ADDR_STATUS)
			next_prdata = {28'h0000000, drive_output_b_o,
				drive_output_a_o, state == ST_RUN, src_sel};
		else
			next_slverr = 1'b1;
	end

	always @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			pready_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end
		else if (psel_i && !penable_i)
		begin
			pready_o <= 1'b1;
			prdata_o <= next_prdata;
			pslverr_o <= next_slverr;
		end
		else
		begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end
	end

	always @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			output_control_reg <= `CMPGEN_RST_OUTCTL;
			input_select_reg <= `CMPGEN_RST_INSEL;
			rising_deadband_count <= `CMPGEN_RST_DB;
			falling_deadband_count <= `CMPGEN_RST_DB;
		end
		else if (wr)
		begin
			if (paddr_i == `CMPGEN_ADDR_OUTCTL)
				output_control_reg <= pwdata_i[7:0] & 8'hf9;
			else if (paddr_i == `CMPGEN_ADDR_INSEL)
				input_select_reg <= pwdata_i[7:0] & 8'h07;
			else if (paddr_i == `CMPGEN_ADDR_DBR)
				rising_deadband_count <= pwdata_i[5:0];
			else if (paddr_i == `CMPGEN_ADDR_DBF)
				falling_deadband_count <= pwdata_i[5:0];
		end
	end

	// the event bit: hardware sets win over software or auto clears
	always @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			shutdown_control_reg <= `CMPGEN_RST_SHDCTL;
		else
		begin
			if (wr && paddr_i == `CMPGEN_ADDR_SHDCTL)
			begin
				shutdown_control_reg[6:0] <= pwdata_i[6:0];
				if (pwdata_i[`CMPGEN_SD_ASE])
					shutdown_control_reg[`CMPGEN_SD_ASE] <= 1'b1;
				else if (!sd_active)
					shutdown_control_reg[`CMPGEN_SD_ASE] <= 1'b0;
			end
			if (module_enable && sd_active)
				shutdown_control_reg[`CMPGEN_SD_ASE] <= 1'b1;
			else if (auto_restart_enable && shutdown_event && !sd_active)
				shutdown_control_reg[`CMPGEN_SD_ASE] <= 1'b0;
		end
	end

	always @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state <= ST_SHUT;
			src_d <= 1'b0;
		end
		else if (!module_enable)
		begin
			state <= ST_SHUT;
			src_d <= src_sel;
		end
		else
		begin
			src_d <= src_sel;
			case (state)
				ST_SHUT:
					if (!shutdown_event && !sd_active && rise)
						state <= ST_RUN;
				ST_RUN:
					if (shutdown_event || sd_active)
						state <= ST_SHUT;
				default:
					state <= ST_SHUT;
			endcase
		end
	end

	// input counts as active for a window of ticks after any edge;
	// the window outlasts the longest dead-band count
	always @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			act_cnt <= 8'h00;
		else if (rise || fall)
			act_cnt <= `CMPGEN_ACT_WINDOW;
		else if (tick && act_cnt != 8'h00)
			act_cnt <= act_cnt - 8'h01;
	end

	// a_on after rising delay, b_on after falling delay
	always @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			a_on <= 1'b0;
			b_on <= 1'b0;
		end
		else if (!module_enable || state != ST_RUN)
		begin
			a_on <= 1'b0;
			b_on <= 1'b0;
		end
		else
		begin
			a_on <= src_sel && rise_done;
			b_on <= !src_sel && fall_done;
		end
	end

	// pin stage; sleep does not gate it since the block has its own clock
	always @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			drive_output_a_o <= 1'b0;
			drive_output_b_o <= 1'b0;
			drive_output_a_oe_n_o <= 1'b1;
			drive_output_b_oe_n_o <= 1'b1;
			fast_osc_request_o <= 1'b0;
		end
		else
		begin
			drive_output_a_oe_n_o <= !(module_enable && output_a_enable);
			drive_output_b_oe_n_o <= !(module_enable && output_b_enable);
			if (!module_enable)
			begin
				drive_output_a_o <= 1'b0;
				drive_output_b_o <= 1'b0;
			end
			else if (state != ST_RUN || sd_active)
			begin
				drive_output_a_o <= override_level_a;
				drive_output_b_o <= override_level_b;
			end
			else
			begin
				drive_output_a_o <= output_a_polarity ? a_on : !a_on;
				drive_output_b_o <= output_b_polarity ? b_on : !b_on;
			end
			fast_osc_request_o <= sleep_i && module_enable &&
				module_clock_select && (act_cnt != 8'h00);
		end
	end
endmodule

/* cmpgen_top_tb.sv */
`timescale 1ns/1ps
module cmpgen_top_tb;
	reg clk_sys_i = 0, reset_n_i = 0, psel_i = 0, penable_i = 0;
	reg pwrite_i = 0, oscillator_output_i = 0, logic_cell_output_i = 0;
	reg sleep_i = 0, re;
	reg [3:0] pwm_out_i = 0, shutdown_src_i = 0;
	reg [11:0] paddr_i = 0;
	reg [31:0] pwdata_i = 0, rd;
	wire [31:0] prdata_o;
	wire pready_o, pslverr_o, fast_osc_request_o, pin_a, pin_b;
	wire drive_output_a_o, drive_output_a_oe_n_o;
	wire drive_output_b_o, drive_output_b_oe_n_o;
	int err_count = 0, compares = 0, seed = 26635;
	int i, k1, k2, t, n1, n2, m1, m2;
	always #2.5 clk_sys_i = ~clk_sys_i;
	cmpgen_top dut_u (.*);
	cmpgen_power_stage stage_u
	(
		.drive_a_i(drive_output_a_o), .drive_a_oe_n_i(drive_output_a_oe_n_o),
		.drive_b_i(drive_output_b_o), .drive_b_oe_n_i(drive_output_b_oe_n_o),
		.pin_a_o(pin_a), .pin_b_o(pin_b)
	);
	task report_and_stop;
		if (err_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// tol is only used for bench latencies, never for design values
	task chk(input logic signed [31:0] got, exp, input int tol);
		compares++;
		if (got !== exp && (tol == 0 || got < exp - tol || got > exp + tol))
		begin
			err_count++;
			$display("mismatch %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	// waits for pready as long as it takes; only the watchdog ends a hang
	task apb(input w, input [11:0] a, input [31:0] d);
		{psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
		@(posedge clk_sys_i) penable_i <= 1;
		while (pready_o !== 1'b1) @(posedge clk_sys_i);
		rd = prdata_o;
		re = pslverr_o;
		{psel_i, penable_i} <= 2'h0;
		@(posedge clk_sys_i);
	endtask
	task rdc(input [11:0] a, input [31:0] m, e);
		apb(0, a, 32'h0);
		chk(rd & m, e, 0);
	endtask
	task pins(input [1:0] e);
		@(negedge clk_sys_i) chk({pin_a, pin_b}, e, 0);
		@(posedge clk_sys_i);
	endtask
	// cycles from input edge to the turn-on of a, then of b
	task lat(output int nr, nf);
		nr = 0;
		nf = 0;
		pwm_out_i[0] <= 1;
		while (pin_a !== 1'b1 && nr < 3000) @(negedge clk_sys_i) nr++;
		@(posedge clk_sys_i) pwm_out_i[0] <= 0;
		while (pin_b !== 1'b1 && nf < 3000) @(negedge clk_sys_i) nf++;
		@(posedge clk_sys_i);
	endtask
	function [1:0] model(input act, pa, pb);
		model = {pa ? act : !act, pb ? !act : act};
	endfunction
	initial
	begin
		cyc(6);
		reset_n_i <= 1;
		cyc(1);
		for (i = 0; i < 6; i++)
			rdc(12'(i * 4), 32'hffffffff, 32'h0);
		apb(0, 12'h018, 32'h0);
		chk(re, 1, 0);
		chk(rd, 0, 0);
		apb(1, 12'h008, 32'haf);
		apb(1, 12'h004, 32'h0);
		apb(1, 12'h000, 32'h78);
		apb(1, 12'h000, 32'hf8);
		pins(2'b01);
		apb(1, 12'h008, 32'h2f);
		sleep_i <= 1;
		lat(n1, m1);
		for (i = 0; i < 2; i++)
		begin
			k1 = 1 + {$random(seed)} % 8;
			k2 = k1 + 1 + {$random(seed)} % 20;
			t = i ? 12 : 1;
			apb(1, 12'h000, 32'hf8 | i);
			apb(1, 12'h00c, k1);
			apb(1, 12'h010, k2);
			lat(n1, m1);
			apb(1, 12'h00c, k2);
			apb(1, 12'h010, k1);
			lat(n2, m2);
			chk(n2 - n1, (k2 - k1) * t, t - 1);
			chk(m1 - m2, (k2 - k1) * t, t - 1);
			if (i)
				chk(fast_osc_request_o, 1, 0);
		end
		apb(1, 12'h000, 32'hf8);
		for (i = 0; i < 8; i++)
		begin
			apb(1, 12'h004, i);
			{logic_cell_output_i, oscillator_output_i, pwm_out_i} <=
				i < 6 ? 6'h01 << i : 6'h3f;
			cyc(80);
			pins(i < 6 ? 2'b10 : 2'b01);
			{logic_cell_output_i, oscillator_output_i, pwm_out_i} <= 6'h00;
			cyc(80);
		end
		apb(1, 12'h004, 32'h0);
		for (i = 0; i < 4; i++)
		begin
			apb(1, 12'h000, 32'he0 | i << 3);
			pwm_out_i <= 4'h1;
			cyc(80);
			pins(model(1, i[0], i[1]));
			pwm_out_i <= 4'h0;
			cyc(80);
			pins(model(0, i[0], i[1]));
		end
		pwm_out_i <= 4'h1;
		cyc(80);
		shutdown_src_i <= 4'h2;
		cyc(10);
		pins(2'b01);
		rdc(12'h008, 32'h80, 32'h80);
		apb(1, 12'h008, 32'h2f);
		rdc(12'h008, 32'h80, 32'h80);
		shutdown_src_i <= 4'h0;
		cyc(10);
		apb(1, 12'h008, 32'h2f);
		rdc(12'h008, 32'h80, 32'h0);
		cyc(40);
		pins(2'b01);
		pwm_out_i <= 4'h0;
		cyc(5);
		pwm_out_i <= 4'h1;
		cyc(80);
		pins(2'b10);
		apb(1, 12'h008, 32'h6f);
		shutdown_src_i <= 4'h8;
		cyc(10);
		rdc(12'h008, 32'h80, 32'h80);
		shutdown_src_i <= 4'h0;
		cyc(10);
		rdc(12'h008, 32'h80, 32'h0);
		apb(1, 12'h000, 32'h78);
		cyc(5);
		chk({drive_output_a_oe_n_o, drive_output_b_oe_n_o}, 2'b11, 0);
		apb(1, 12'h008, 32'haf);
		apb(1, 12'h000, 32'hf8);
		apb(1, 12'h008, 32'hef);
		cyc(10);
		rdc(12'h008, 32'h80, 32'h0);
		apb(1, 12'h000, 32'hd8);
		cyc(5);
		chk({drive_output_a_oe_n_o, drive_output_b_oe_n_o}, 2'b10, 0);
		apb(1, 12'h000, 32'h79);
		cyc(5);
		chk(fast_osc_request_o, 0, 0);
		report_and_stop;
	end
	initial
	begin
		#400000;
		err_count++;
		report_and_stop;
	end
endmodule
